/* File: logic/multi_supply_switch_sequencer.v */
// Purpose: Decides when four supply pass switches turn on and off, simultaneous or sequenced.
// Assumes: All inputs synchronous to clk_i; analog crossings arrive as one-cycle events.
// Notes:   Bit 0..3 of every vector are +12V, 5V, 3.3V, -12V.
`include "supply_seq_consts.vh"

// What this block does
// - Switches may turn on only after start-up conditions held 100ms without break.
// - All supplies above lockout; negative lockout ignored unless config pin tied low.
// - No undervoltage, overcurrent or downstream fault set, unless that type auto-retries.
// - Internal supply rising makes a reset pulse clearing faults and control bits.
// - On qualification sample enable; set all commands, or only first when sequencing.
// - If enable low, turn on later on enable rise or host turn-on write.
// - Current-limit faults of ramping supplies are ignored while the timer climbs.
// - At timer low crossing: reset soft-start, arm breaker, raise limit to three times.
// - Sequenced mode starts the next ramp; host-driven waits for next command.
// - All on and in tolerance: assert good, follow bus reset, downstream-good check.
// - Enable falling or board select going high turns off all switches.
// - Clearing one command bit turns off only that supply's switch.
// - Undervoltage, breaker trip or downstream-good fault turns off all switches.
// - Host writing one to a fault bit turns all off unless it auto-retries.
// - Any switch shut off releases supply good and drives local reset low.
// - Control register: commands in low nibble, on-state in high nibble.
// - Without sequencing, enable rise sets all commands; one shared ramp cycle.
// - With sequencing, enable sets first bit; each ramp end sets the next.
// - Sequencing: condition loss turns all off and clears bits 1-3; also on insertion.
// - Sequencing: host set chains onward; chain stops at a supply already powered.
// - Command sets ignored while ramping, busy flag shown; clears allowed; sets ramp together unless sequencing.
module multi_supply_switch_sequencer #(
  parameter QUAL_CYCLES = `QUAL_CYCLES,
  parameter POR_CYCLES  = `POR_CYCLES
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Supply monitors
  input  wire [3:0] lockout_ok_i,
  input  wire       internal_supply_ok_i,
  input  wire       cfg_tied_low_i,
  input  wire       out_in_tol_i,
  input  wire [3:0] uv_event_i,
  input  wire [3:0] breaker_trip_i,
  input  wire [3:0] in_current_limit_i,
  // Backplane and board pins
  input  wire       board_select_n_i,
  input  wire       enable_pin_i,
  input  wire       bus_reset_n_i,
  input  wire       downstream_good_input_i,
  // Timing ramp comparator events
  input  wire       timer_hi_cross_i,
  input  wire       timer_lo_cross_i,
  input  wire       ss_open_loop_i,
  // Register port
  input  wire       reg_wr_i,
  input  wire [1:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  // Switch and ramp controls
  output reg  [3:0] switch_on_o,
  output reg  [3:0] breaker_arm_o,
  output reg  [3:0] high_limit_o,
  output reg  [3:0] cl_fault_mask_o,
  output reg        timer_charge_o,
  output reg        timer_pg_charge_o,
  output reg        ss_charge_o,
  output reg        ss_low_current_o,
  output reg        ss_reset_o,
  output reg        ramp_busy_flag_o,
  // Status pins
  output reg        supply_good_n_o,
  output reg        supply_good_n_oe_o,
  output reg        local_reset_n_o
);
  localparam [6:0] ST_WAIT  = 7'h01;
  localparam [6:0] ST_READY = 7'h02;
  localparam [6:0] ST_RHI   = 7'h04;
  localparam [6:0] ST_RLO   = 7'h08;
  localparam [6:0] ST_PGHI  = 7'h10;
  localparam [6:0] ST_PGLO  = 7'h20;
  localparam [6:0] ST_RUN   = 7'h40;
  localparam [`POR_CNT_W-1:0] POR_LOAD = POR_CYCLES[`POR_CNT_W-1:0];

  // Picks the lowest set bit so sequenced ramps take one supply at a time
  function [3:0] lowest_bit;
    input [3:0] v;
    begin
      lowest_bit = v & (~v + 4'h1);
    end
  endfunction

  reg [6:0]            state_ff, nxt_state;
  reg [3:0]            cmd_ff, nxt_cmd;
  reg [3:0]            on_ff, nxt_on;
  reg [3:0]            ramp_ff, nxt_ramp;
  reg [3:0]            arm_ff, nxt_arm;
  reg [2:0]            fault_ff, nxt_fault;
  reg [7:0]            cfg_ff, nxt_cfg;
  reg                  isup_d_ff;
  reg                  en_d_ff;
  reg                  bsel_d_ff;
  reg                  qual_d_ff;
  reg [`POR_CNT_W-1:0] por_cnt_ff;
  reg                  por_ff;
  wire                 qual_ok;
  wire                 seq_mode  = cfg_ff[`CFG_SEQ_BIT];
  wire                 wr_ctrl   = reg_wr_i && (reg_addr_i == `REG_SWITCH_CTRL);
  wire                 wr_fault  = reg_wr_i && (reg_addr_i == `REG_FAULT);
  wire                 wr_cfg    = reg_wr_i && (reg_addr_i == `REG_CONFIG);
  wire                 busy      = state_ff[2] | state_ff[3];
  wire [2:0]           retry     = {cfg_ff[`CFG_RETRY_DG_BIT], cfg_ff[`CFG_RETRY_OC_BIT],
                                    cfg_ff[`CFG_RETRY_UV_BIT]};
  wire                 lockouts  = &lockout_ok_i[2:0] &
                                   (lockout_ok_i[3] | ~cfg_tied_low_i);
  wire                 blocking  = |(fault_ff & ~retry);
  wire                 cond_now  = lockouts & internal_supply_ok_i & ~board_select_n_i &
                                   ~blocking & ~por_ff;
  wire                 qual_rise = qual_ok & ~qual_d_ff;
  wire                 en_rise   = enable_pin_i & ~en_d_ff;
  wire                 en_fall   = ~enable_pin_i & en_d_ff;
  wire                 bsel_fall = ~board_select_n_i & bsel_d_ff;
  wire                 bsel_rise = board_select_n_i & ~bsel_d_ff;
  wire                 good_now;

  // Continuous-hold qualifier for switch turn-on
  cycle_qualifier #(
    .CYCLES (QUAL_CYCLES),
    .W      (`QUAL_CNT_W)
  ) u_qual (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cond_i (cond_now),
    .done_o (qual_ok)
  );

  // Internal reset pulse on every rise of the internal supply
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      isup_d_ff  <= 1'b0;
      por_cnt_ff <= {`POR_CNT_W{1'b0}};
      por_ff     <= 1'b0;
    end else begin
      isup_d_ff <= internal_supply_ok_i;
      if (internal_supply_ok_i && !isup_d_ff) begin
        por_cnt_ff <= POR_LOAD;
        por_ff     <= 1'b1;
      end else if (por_cnt_ff != {`POR_CNT_W{1'b0}}) begin
        por_cnt_ff <= por_cnt_ff - {{(`POR_CNT_W-1){1'b0}}, 1'b1};
      end else begin
        por_ff <= 1'b0;
      end
    end
  end

  assign good_now = (&on_ff) & out_in_tol_i & (state_ff[4] | state_ff[5] | state_ff[6]);

  always @* begin
    nxt_state = state_ff;
    nxt_cmd   = cmd_ff;
    nxt_on    = on_ff;
    nxt_ramp  = ramp_ff;
    nxt_arm   = arm_ff;
    nxt_fault = fault_ff;
    nxt_cfg   = cfg_ff;
    if (wr_cfg) begin
      nxt_cfg = reg_wdata_i;
    end
    // Host clears are honoured at any time, sets only outside a ramp
    if (wr_ctrl) begin
      nxt_cmd = busy ? (cmd_ff & reg_wdata_i[3:0]) : reg_wdata_i[3:0];
    end
    if (qual_rise && enable_pin_i || qual_ok && en_rise) begin
      nxt_cmd = seq_mode ? (nxt_cmd | 4'h1) : 4'hf;
    end
    if (seq_mode && bsel_fall) begin
      nxt_cmd[3:1] = 3'h0;
    end
    if (wr_fault) begin
      nxt_fault = reg_wdata_i[2:0];
    end
    nxt_on  = on_ff & nxt_cmd;
    nxt_arm = arm_ff & nxt_cmd;

    case (state_ff)
      ST_WAIT: begin
        if (qual_ok) begin
          nxt_state = ST_READY;
        end
      end
      ST_READY: begin
        if ((nxt_cmd & ~on_ff) != 4'h0) begin
          nxt_ramp  = seq_mode ? lowest_bit(nxt_cmd & ~on_ff) : (nxt_cmd & ~on_ff);
          nxt_on    = nxt_on | nxt_ramp;
          nxt_state = ST_RHI;
        end else if ((&on_ff) && out_in_tol_i) begin
          nxt_state = ST_PGHI;
        end
      end
      ST_RHI: begin
        if (timer_hi_cross_i) begin
          nxt_state = ST_RLO;
        end
      end
      ST_RLO: begin
        if (timer_lo_cross_i) begin
          if ((in_current_limit_i & ramp_ff) != 4'h0) begin
            nxt_fault[`FLT_OC_BIT] = 1'b1;
            nxt_on                 = 4'h0;
          end else begin
            nxt_arm = nxt_arm | (ramp_ff & nxt_on);
            if (seq_mode) begin
              // Chain onward, but stop at a supply that is already up
              nxt_cmd = nxt_cmd | ({ramp_ff[2:0], 1'b0} & ~on_ff);
            end
          end
          nxt_ramp  = 4'h0;
          nxt_state = ST_READY;
        end
      end
      ST_PGHI: begin
        if (timer_hi_cross_i) begin
          nxt_state = ST_PGLO;
        end
      end
      ST_PGLO: begin
        if (timer_lo_cross_i) begin
          if (!downstream_good_input_i) begin
            nxt_fault[`FLT_DG_BIT] = 1'b1;
            nxt_on                 = 4'h0;
          end
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if ((nxt_cmd & ~on_ff) != 4'h0 || !(&nxt_on)) begin
          nxt_state = ST_READY;
        end
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase

    // Hardware fault events win over a host clear in the same cycle
    if (|uv_event_i) begin
      nxt_fault[`FLT_UV_BIT] = 1'b1;
    end
    if (|(breaker_trip_i & arm_ff)) begin
      nxt_fault[`FLT_OC_BIT] = 1'b1;
    end
    if (|uv_event_i || |(breaker_trip_i & arm_ff)) begin
      nxt_on = 4'h0;
    end
    if (wr_fault && |(reg_wdata_i[2:0] & ~retry)) begin
      nxt_on = 4'h0;
    end
    if (en_fall || board_select_n_i || bsel_rise) begin
      nxt_on = 4'h0;
    end
    if (en_fall) begin
      nxt_cmd = 4'h0;
    end
    if (!cond_now || !qual_ok) begin
      nxt_on = 4'h0;
      if (seq_mode) begin
        nxt_cmd[3:1] = 3'h0;
      end
    end
    // A ramp about to start with every switch forced off is dropped, not left climbing
    if (!qual_ok && qual_d_ff || nxt_on == 4'h0 && (on_ff | nxt_ramp) != 4'h0) begin
      nxt_ramp  = 4'h0;
      nxt_state = qual_ok ? ST_READY : ST_WAIT;
    end
    nxt_arm = nxt_arm & nxt_on;
    if (por_ff) begin
      nxt_fault = `RST_FAULT;
      nxt_cfg   = `RST_CONFIG;
      nxt_cmd   = `RST_SWITCH_CTRL;
      nxt_on    = 4'h0;
      nxt_arm   = 4'h0;
      nxt_ramp  = 4'h0;
      nxt_state = ST_WAIT;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= ST_WAIT;
      cmd_ff    <= `RST_SWITCH_CTRL;
      on_ff     <= 4'h0;
      ramp_ff   <= 4'h0;
      arm_ff    <= 4'h0;
      fault_ff  <= `RST_FAULT;
      cfg_ff    <= `RST_CONFIG;
      en_d_ff   <= 1'b0;
      bsel_d_ff <= 1'b1;
      qual_d_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cmd_ff    <= nxt_cmd;
      on_ff     <= nxt_on;
      ramp_ff   <= nxt_ramp;
      arm_ff    <= nxt_arm;
      fault_ff  <= nxt_fault;
      cfg_ff    <= nxt_cfg;
      en_d_ff   <= enable_pin_i;
      bsel_d_ff <= board_select_n_i;
      qual_d_ff <= qual_ok;
    end
  end

  // Output flops; the analog side sees only levels, never the state code
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      switch_on_o        <= 4'h0;
      breaker_arm_o      <= 4'h0;
      high_limit_o       <= 4'h0;
      cl_fault_mask_o    <= 4'h0;
      timer_charge_o     <= 1'b0;
      timer_pg_charge_o  <= 1'b0;
      ss_charge_o        <= 1'b0;
      ss_low_current_o   <= 1'b0;
      ss_reset_o         <= 1'b1;
      ramp_busy_flag_o   <= 1'b0;
      supply_good_n_o    <= 1'b0;
      supply_good_n_oe_o <= 1'b0;
      local_reset_n_o    <= 1'b0;
      reg_rdata_o        <= 8'h00;
    end else begin
      switch_on_o       <= nxt_on;
      breaker_arm_o     <= nxt_arm;
      high_limit_o      <= nxt_arm;
      cl_fault_mask_o   <= (nxt_state == ST_RHI) ? (nxt_ramp & nxt_on) : 4'h0;
      timer_charge_o    <= (nxt_state == ST_RHI);
      timer_pg_charge_o <= (nxt_state == ST_PGHI);
      ss_charge_o       <= (nxt_state == ST_RHI) || (nxt_state == ST_RLO);
      // Slow the soft-start when an amplifier has gone open loop
      ss_low_current_o  <= ss_open_loop_i && ((nxt_state == ST_RHI) || (nxt_state == ST_RLO));
      ss_reset_o        <= !((nxt_state == ST_RHI) || (nxt_state == ST_RLO));
      ramp_busy_flag_o  <= (nxt_state == ST_RHI) || (nxt_state == ST_RLO);
      // Open-drain: drive low when good, release otherwise
      supply_good_n_o    <= 1'b0;
      supply_good_n_oe_o <= good_now && (&nxt_on);
      local_reset_n_o    <= good_now && (&nxt_on) && bus_reset_n_i;
      case (reg_addr_i)
        `REG_SWITCH_CTRL: reg_rdata_o <= {on_ff, cmd_ff};
        `REG_FAULT:       reg_rdata_o <= {5'h00, fault_ff};
        `REG_CONFIG:      reg_rdata_o <= cfg_ff;
        `REG_STATUS:      reg_rdata_o <= {5'h00, good_now, busy, qual_ok};
        default:          reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // multi_supply_switch_sequencer

/* File: logic/supply_seq_consts.vh */
// Purpose: Shared constants for the multi-supply switch sequencer.
// Assumes: 250 MHz core clock.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef SUPPLY_SEQ_CONSTS_VH
`define SUPPLY_SEQ_CONSTS_VH

`define CLK_MHZ            250
`define QUAL_TIME_MS       100
`define QUAL_CYCLES        (`QUAL_TIME_MS * 1000 * `CLK_MHZ)
`define QUAL_CNT_W         25
`define POR_TIME_US        90
`define POR_CYCLES         (`POR_TIME_US * `CLK_MHZ)
`define POR_CNT_W          15

// Register indices on the register port
`define REG_SWITCH_CTRL    2'h0
`define REG_FAULT          2'h1
`define REG_CONFIG         2'h2
`define REG_STATUS         2'h3

// Fault register fields
`define FLT_UV_BIT         0
`define FLT_OC_BIT         1
`define FLT_DG_BIT         2

// Config register fields
`define CFG_RETRY_UV_BIT   0
`define CFG_RETRY_OC_BIT   1
`define CFG_RETRY_DG_BIT   4
`define CFG_SEQ_BIT        6

// Status register fields
`define STS_BUSY_BIT       1
`define STS_QUAL_BIT       0
`define STS_GOOD_BIT       2

// Reset values
`define RST_SWITCH_CTRL    4'h0
`define RST_FAULT          3'h0
`define RST_CONFIG         8'h00

`endif

/* File: logic/cycle_qualifier.v */
// Purpose: Flags a condition that has held continuously for a set number of cycles.
// Assumes: cond_i synchronous to clk_i.
// Notes:   Any drop of the condition restarts the count from zero.
module cycle_qualifier #(
  parameter CYCLES = 25000000,
  parameter W      = 25
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Condition and result
  input  wire cond_i,
  output reg  done_o
);
  localparam integer LAST_FULL = CYCLES - 1;
  localparam [W-1:0] LAST      = LAST_FULL[W-1:0];
  reg [W-1:0] cnt_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (!cond_i) begin
      cnt_ff <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (cnt_ff == LAST) begin
      done_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // cycle_qualifier

/* File: testbench/supply_seq_props.sv */
// Purpose: Port-level checks for the multi-supply switch sequencer.
// Assumes: One clock domain; rst_i async active high.
// Notes:   Qualification counter tracks board select, internal supply and positive lockouts.
module supply_seq_props #(
  parameter int QUAL_CYCLES = 25000000
) (
  input wire       clk_i, rst_i, internal_supply_ok_i, board_select_n_i, enable_pin_i,
  input wire       bus_reset_n_i, timer_lo_cross_i, timer_charge_o, ramp_busy_flag_o,
  input wire       ss_reset_o, supply_good_n_o, supply_good_n_oe_o, local_reset_n_o,
  input wire [3:0] lockout_ok_i, uv_event_i, switch_on_o, breaker_arm_o, high_limit_o,
  input wire [3:0] cl_fault_mask_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int qual_cnt_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Saturates so a long run never wraps
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) qual_cnt_ff <= 0;
    else if (board_select_n_i || !internal_supply_ok_i || lockout_ok_i[2:0] != 3'h7)
      qual_cnt_ff <= 0;
    else if (qual_cnt_ff < QUAL_CYCLES) qual_cnt_ff <= qual_cnt_ff + 1;
  end
  property p_qual;
    (switch_on_o & ~$past(switch_on_o)) != 4'h0 |-> qual_cnt_ff >= QUAL_CYCLES;
  endproperty
  a_qual: assert property (p_qual) else $error("switch on before qualification");
  property p_mask;
    cl_fault_mask_o != 4'h0 |-> timer_charge_o && (cl_fault_mask_o & ~switch_on_o) == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("limit mask outside a climb");
  property p_end;
    timer_lo_cross_i && ramp_busy_flag_o && !timer_charge_o |->
      ##1 ss_reset_o && !ramp_busy_flag_o && breaker_arm_o != 4'h0;
  endproperty
  a_end: assert property (p_end) else $error("ramp end not handled");
  property p_arm; breaker_arm_o == high_limit_o; endproperty
  a_arm: assert property (p_arm) else $error("breaker and limit differ");
  property p_follow;
    supply_good_n_oe_o && $past(supply_good_n_oe_o) |-> local_reset_n_o == $past(bus_reset_n_i);
  endproperty
  a_follow: assert property (p_follow) else $error("local reset not following");
  property p_en_off; $fell(enable_pin_i) |-> ##[1:3] switch_on_o == 4'h0; endproperty
  a_en_off: assert property (p_en_off) else $error("enable fall left switches on");
  property p_bs_off; board_select_n_i |-> ##[1:3] switch_on_o == 4'h0; endproperty
  a_bs_off: assert property (p_bs_off) else $error("removal left switches on");
  property p_uv_off; uv_event_i != 4'h0 |-> ##[1:3] switch_on_o == 4'h0; endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage left switches on");
  property p_good_rel; switch_on_o != 4'hf |-> ##[0:1] !supply_good_n_oe_o; endproperty
  a_good_rel: assert property (p_good_rel) else $error("good held with a switch off");
  property p_lrst; !supply_good_n_oe_o |-> ##[0:1] !local_reset_n_o; endproperty
  a_lrst: assert property (p_lrst) else $error("local reset released while not good");
  property p_good_lvl; supply_good_n_o == 1'b0; endproperty
  a_good_lvl: assert property (p_good_lvl) else $error("good pin drives high");
endmodule // supply_seq_props
bind multi_supply_switch_sequencer supply_seq_props #(.QUAL_CYCLES(QUAL_CYCLES)) props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .internal_supply_ok_i(internal_supply_ok_i),
  .board_select_n_i(board_select_n_i), .enable_pin_i(enable_pin_i),
  .bus_reset_n_i(bus_reset_n_i), .timer_lo_cross_i(timer_lo_cross_i),
  .timer_charge_o(timer_charge_o), .ramp_busy_flag_o(ramp_busy_flag_o),
  .ss_reset_o(ss_reset_o), .supply_good_n_o(supply_good_n_o),
  .supply_good_n_oe_o(supply_good_n_oe_o), .local_reset_n_o(local_reset_n_o),
  .lockout_ok_i(lockout_ok_i), .uv_event_i(uv_event_i), .switch_on_o(switch_on_o),
  .breaker_arm_o(breaker_arm_o), .high_limit_o(high_limit_o),
  .cl_fault_mask_o(cl_fault_mask_o));

/* File: testbench/timer_ramp_model.sv */
// Purpose: Timing ramp comparators answering the sequencer's ramp current controls.
// Assumes: Ramp climbs only while charge_i is high.
// Notes:   Short climb and fall counts keep the run brief.
module timer_ramp_model #(
  parameter int RISE = 8,
  parameter int FALL = 4
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Ramp current and crossings
  input  wire logic charge_i,
  output logic      hi_cross_o,
  output logic      lo_cross_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt_ff;
  logic falling_ff;
  // Crossings are one-cycle events, never levels
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff     <= 0;
      falling_ff <= 1'b0;
      hi_cross_o <= 1'b0;
      lo_cross_o <= 1'b0;
    end else begin
      hi_cross_o <= 1'b0;
      lo_cross_o <= 1'b0;
      cnt_ff     <= cnt_ff + 1;
      if (falling_ff && cnt_ff == FALL) begin
        lo_cross_o <= 1'b1;
        falling_ff <= 1'b0;
        cnt_ff     <= 0;
      end else if (!falling_ff && cnt_ff == RISE) begin
        hi_cross_o <= 1'b1;
        falling_ff <= 1'b1;
        cnt_ff     <= 0;
      end else if (!falling_ff && !charge_i) begin
        cnt_ff <= 0;
      end
    end
  end
endmodule // timer_ramp_model

/* File: testbench/test_multi_supply_switch_sequencer.sv */
// Purpose: Register-level scenarios for the multi-supply switch sequencer.
// Assumes: Short qualification and power-on counts set through parameters.
// Notes:   Supply good is open drain with a pull-up, resolved here.
module test_multi_supply_switch_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QUAL = 50;
  logic       clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0;
  logic [3:0] lockout_ok_i = 4'hf, uv_event_i = 4'h0;
  logic       internal_supply_ok_i = 1'b1, cfg_tied_low_i = 1'b1, out_in_tol_i = 1'b1;
  logic       board_select_n_i = 1'b0;
  logic       enable_pin_i = 1'b0, bus_reset_n_i = 1'b1, downstream_good_input_i = 1'b1;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [3:0] breaker_trip_i = 4'h0;
  logic       ss_open_loop_i = 1'b0;
  wire  [7:0] reg_rdata_o;
  wire  [3:0] switch_on_o, breaker_arm_o, high_limit_o, cl_fault_mask_o;
  wire        timer_charge_o, timer_pg_charge_o, ss_charge_o, ss_low_current_o, ss_reset_o;
  wire        ramp_busy_flag_o, supply_good_n_o, supply_good_n_oe_o, local_reset_n_o;
  wire        timer_hi_cross_i, timer_lo_cross_i;
  wire        good_wire = supply_good_n_oe_o ? supply_good_n_o : 1'b1;
  int         mismatches = 0, checks_done = 0, cycles = 0;

  multi_supply_switch_sequencer #(.QUAL_CYCLES(QUAL), .POR_CYCLES(8))
    multi_supply_switch_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .lockout_ok_i(lockout_ok_i),
    .internal_supply_ok_i(internal_supply_ok_i), .cfg_tied_low_i(cfg_tied_low_i),
    .out_in_tol_i(out_in_tol_i), .uv_event_i(uv_event_i), .breaker_trip_i(breaker_trip_i),
    .in_current_limit_i(4'h0), .board_select_n_i(board_select_n_i),
    .enable_pin_i(enable_pin_i), .bus_reset_n_i(bus_reset_n_i),
    .downstream_good_input_i(downstream_good_input_i), .timer_hi_cross_i(timer_hi_cross_i),
    .timer_lo_cross_i(timer_lo_cross_i), .ss_open_loop_i(ss_open_loop_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .switch_on_o(switch_on_o), .breaker_arm_o(breaker_arm_o), .high_limit_o(high_limit_o),
    .cl_fault_mask_o(cl_fault_mask_o), .timer_charge_o(timer_charge_o),
    .timer_pg_charge_o(timer_pg_charge_o), .ss_charge_o(ss_charge_o),
    .ss_low_current_o(ss_low_current_o), .ss_reset_o(ss_reset_o),
    .ramp_busy_flag_o(ramp_busy_flag_o), .supply_good_n_o(supply_good_n_o),
    .supply_good_n_oe_o(supply_good_n_oe_o), .local_reset_n_o(local_reset_n_o));
  timer_ramp_model timer_ramp_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .charge_i(timer_charge_o | timer_pg_charge_o), .hi_cross_o(timer_hi_cross_i),
    .lo_cross_o(timer_lo_cross_i));

  always #2 clk_i = ~clk_i;
  // Whole sequence needs about 1100 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Trailing idle cycle keeps back-to-back strobes apart
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    cyc(2);
    chk(reg_rdata_o, exp);
  endtask
  // Waits for the switches to leave one pattern, then checks the next one
  task automatic wait_sw(input logic [3:0] from, input logic [3:0] to);
    int n;
    n = 0;
    while (switch_on_o === from && n < 400) begin
      cyc(1);
      n++;
    end
    chk({4'h0, switch_on_o}, {4'h0, to});
  endtask

  initial begin
    cyc(16);
    rst_i = 1'b0;
    cyc(2);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    enable_pin_i = 1'b1;
    cyc(20);
    chk({4'h0, switch_on_o}, 8'h00);
    wait_sw(4'h0, 4'hf);
    cyc(30);
    chk({7'h0, good_wire}, 8'h00);
    bus_reset_n_i = 1'b0;
    cyc(2);
    chk({7'h0, local_reset_n_o}, 8'h00);
    bus_reset_n_i = 1'b1;
    cyc(2);
    chk({7'h0, local_reset_n_o}, 8'h01);
    rd(2'h0, 8'hff);
    wr(2'h0, 8'h0d);
    wait_sw(4'hf, 4'hd);
    cyc(1);
    chk({6'h0, good_wire, local_reset_n_o}, 8'h02);
    enable_pin_i = 1'b0;
    wait_sw(4'hd, 4'h0);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h01);
    wait_sw(4'h0, 4'h1);
    ss_open_loop_i = 1'b1;
    wr(2'h0, 8'h03);
    rd(2'h3, 8'h03);
    chk({5'h0, ss_low_current_o, ss_charge_o, ss_reset_o}, 8'h06);
    ss_open_loop_i = 1'b0;
    cyc(30);
    rd(2'h0, 8'h11);
    wr(2'h0, 8'h0f);
    wait_sw(4'h1, 4'hf);
    wr(2'h1, 8'h01);
    wait_sw(4'hf, 4'h0);
    rd(2'h1, 8'h01);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h40);
    rd(2'h2, 8'h40);
    cfg_tied_low_i = 1'b0;
    lockout_ok_i = 4'h7;
    enable_pin_i = 1'b1;
    wait_sw(4'h0, 4'h1);
    wait_sw(4'h1, 4'h3);
    wait_sw(4'h3, 4'h7);
    wait_sw(4'h7, 4'hf);
    lockout_ok_i = 4'h3;
    wait_sw(4'hf, 4'h0);
    rd(2'h0, 8'h01);
    lockout_ok_i = 4'h7;
    cyc(200);
    chk({4'h0, switch_on_o}, 8'h0f);
    wr(2'h2, 8'h41);
    wr(2'h1, 8'h01);
    cyc(2);
    chk({4'h0, switch_on_o}, 8'h0f);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h40);
    uv_event_i = 4'h2;
    cyc(1);
    uv_event_i = 4'h0;
    wait_sw(4'hf, 4'h0);
    rd(2'h1, 8'h01);
    wr(2'h1, 8'h00);
    cyc(200);
    chk({4'h0, switch_on_o}, 8'h0f);
    chk({4'h0, breaker_arm_o}, 8'h0f);
    board_select_n_i = 1'b1;
    cyc(3);
    chk({4'h0, switch_on_o}, 8'h00);
    board_select_n_i = 1'b0;
    cyc(200);
    chk({4'h0, switch_on_o}, 8'h0f);
    breaker_trip_i = 4'h4;
    cyc(1);
    breaker_trip_i = 4'h0;
    wait_sw(4'hf, 4'h0);
    rd(2'h1, 8'h02);
    enable_pin_i = 1'b0;
    wr(2'h1, 8'h00);
    cyc(60);
    wr(2'h0, 8'h02);
    wait_sw(4'h0, 4'h2);
    wait_sw(4'h2, 4'h6);
    wait_sw(4'h6, 4'he);
    cyc(30);
    downstream_good_input_i = 1'b0;
    wr(2'h0, 8'h0f);
    wait_sw(4'he, 4'hf);
    wait_sw(4'hf, 4'h0);
    rd(2'h1, 8'h04);
    stop_test();
  end
endmodule // test_multi_supply_switch_sequencer
